// ---- include/ebrg_defs.svh ----
/*
 * Constants for the external bus request and grant block.
 * Assumes inclusion by bare name from the include path.
 */
`ifndef EBRG_DEFS_SVH
`define EBRG_DEFS_SVH

// ****************************************
// Reset values
// ****************************************
`define EBRG_GRANT_RST 1'b0
`define EBRG_HANG_RST 1'b0
`define EBRG_STATE_RST 2'h0

`endif

// ---- include/ebrg_pkg.sv ----
/*
 * Types for the external bus request and grant block.
 * Assumes nothing of its surroundings.
 */
package ebrg_pkg;

  typedef enum logic [1:0] {
    EBRG_OWN = 2'b00,
    EBRG_GRANTED = 2'b01
  } ebrg_state_e;

endpackage

// ---- rtl/ebrg_arbiter.sv ----
/*
 * Bus request and grant handshake of the processor's external memory bus.
 * Assumes the sequencer reports access and instruction status on the core
 * clock, and that pin inputs are asynchronous to it.
 */
`include "ebrg_defs.svh"

// Functional notes
// - Free bus: a request is granted next cycle, drivers off, execution halted.
// - Continue mode runs on after the grant until an access is needed.
// - A request during an access is granted the cycle after it completes.
// - The grant may fall between two accesses of one instruction.
// - Dropping the request drops grant, restores drivers and resumes.
// - The handshake works in every state, in boot and while reset is held.
// - Grant-hang shows while an instruction waits on a granted-away bus.
// - On return, grant and grant-hang drop and the pending access runs.
// - Under emulation, reset, request and grant use the alternate pins.
// - Under emulation the normal grant output is left undriven.
module ebrg_arbiter (
  // Clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  // Pins
  input wire logic EXT_BUS_REQ_N_I,
  input wire logic EMU_ALT_BUS_REQ_N_I,
  input wire logic EMU_ALT_RESET_N_I,
  input wire logic EMULATOR_ENABLE_I,
  // Sequencer status
  input wire logic ACCESS_BUSY_I,
  input wire logic ACCESS_WANTED_I,
  input wire logic CONTINUE_MODE_I,
  // Outputs
  output logic EXT_BUS_GRANT_N_O,
  output logic EXT_BUS_GRANT_OE_O,
  output logic EMU_ALT_BUS_GRANT_N_O,
  output logic GRANT_HANG_N_O,
  output logic BUS_DRIVE_EN_O,
  output logic CORE_HALT_O,
  output logic CORE_RESET_N_O
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic [3:0] sync1_next;
  logic [3:0] sync2_next;

  always_comb
  begin
    sync1_next = {EMULATOR_ENABLE_I, EMU_ALT_RESET_N_I,
                  EMU_ALT_BUS_REQ_N_I, EXT_BUS_REQ_N_I};
    sync2_next = sync1_reg;
  end

  // No reset here so the request path works while reset is held
  always_ff @(posedge CORE_CLK_I)
  begin
    sync1_reg <= sync1_next;
    sync2_reg <= sync2_next;
  end

  logic emu_on;
  logic req_act;
  assign emu_on = sync2_reg[3];
  // Request source follows emulator enable
  assign req_act = emu_on ? !sync2_reg[1] : !sync2_reg[0];

  // ****************************************
  // Grant state machine
  // ****************************************
  ebrg_pkg::ebrg_state_e state_reg;
  ebrg_pkg::ebrg_state_e state_next;
  logic grant;

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ebrg_pkg::EBRG_OWN:
      begin
        // Busy cycle defers grant past the access end
        if (req_act && !ACCESS_BUSY_I)
          state_next = ebrg_pkg::EBRG_GRANTED;
      end
      ebrg_pkg::EBRG_GRANTED:
      begin
        // Bus comes back as soon as the request level drops
        if (!req_act)
          state_next = ebrg_pkg::EBRG_OWN;
      end
      default:
        state_next = ebrg_pkg::EBRG_OWN;
    endcase
    // Outputs follow the next state to save a cycle of latency
    grant = (state_next == ebrg_pkg::EBRG_GRANTED);
  end

  // Reset deliberately leaves the grant logic alone
  always_ff @(posedge CORE_CLK_I)
  begin
    state_reg <= state_next;
  end

  // ****************************************
  // Output registers
  // ****************************************
  logic gnt_n_reg;
  logic gnt_n_next;
  logic gnt_oe_reg;
  logic gnt_oe_next;
  logic egnt_n_reg;
  logic egnt_n_next;
  logic hang_n_reg;
  logic hang_n_next;
  logic drv_reg;
  logic drv_next;
  logic halt_reg;
  logic halt_next;
  logic rst_n_reg;
  logic rst_n_next;

  always_comb
  begin
    gnt_n_next = !grant;
    // Pin floats under emulation; the pad honours the enable
    gnt_oe_next = !emu_on;
    egnt_n_next = emu_on ? !grant : 1'h1;
    drv_next = !grant;
    // Stalled only when the next instruction needs the bus
    hang_n_next = !(grant && ACCESS_WANTED_I);
    // Continue mode keeps running until the bus is needed
    halt_next = grant && (ACCESS_WANTED_I || !CONTINUE_MODE_I);
    // Reset source follows emulator enable
    rst_n_next = emu_on ? sync2_reg[2] : RST_N_I;
  end

  // No reset: outputs settle within three clocks of power-up
  always_ff @(posedge CORE_CLK_I)
  begin
    gnt_n_reg <= gnt_n_next;
    gnt_oe_reg <= gnt_oe_next;
    egnt_n_reg <= egnt_n_next;
    hang_n_reg <= hang_n_next;
    drv_reg <= drv_next;
    halt_reg <= halt_next;
    rst_n_reg <= rst_n_next;
  end

  assign EXT_BUS_GRANT_N_O = gnt_n_reg;
  assign EXT_BUS_GRANT_OE_O = gnt_oe_reg;
  assign EMU_ALT_BUS_GRANT_N_O = egnt_n_reg;
  assign GRANT_HANG_N_O = hang_n_reg;
  assign BUS_DRIVE_EN_O = drv_reg;
  assign CORE_HALT_O = halt_reg;
  assign CORE_RESET_N_O = rst_n_reg;

  // ****************************************
  // Checks
  // ****************************************
  sequence req_free_s;
    req_act && !ACCESS_BUSY_I && state_reg == ebrg_pkg::EBRG_OWN;
  endsequence

  sequence req_drop_s;
    !req_act && state_reg == ebrg_pkg::EBRG_GRANTED;
  endsequence

  sequence req_hold_s;
    req_act && state_reg == ebrg_pkg::EBRG_GRANTED;
  endsequence

  grant_on_free_a: assert property (@(posedge CORE_CLK_I)
    req_free_s |=> !EXT_BUS_GRANT_N_O && !BUS_DRIVE_EN_O)
    else $error("grant not given after free request");
  busy_defer_a: assert property (@(posedge CORE_CLK_I)
    ACCESS_BUSY_I && state_reg == ebrg_pkg::EBRG_OWN |=> drv_reg)
    else $error("grant given during access");
  release_a: assert property (@(posedge CORE_CLK_I)
    req_drop_s |=> drv_reg)
    else $error("drivers not restored");
  hang_match_a: assert property (@(posedge CORE_CLK_I)
    !GRANT_HANG_N_O |-> !drv_reg)
    else $error("hang without grant");
  continue_run_a: assert property (@(posedge CORE_CLK_I)
    grant && CONTINUE_MODE_I && !ACCESS_WANTED_I |=> !CORE_HALT_O)
    else $error("halted in continue mode");
  emu_float_a: assert property (@(posedge CORE_CLK_I)
    emu_on |=> !EXT_BUS_GRANT_OE_O)
    else $error("grant driven under emulation");
  hang_clear_a: assert property (@(posedge CORE_CLK_I)
    !grant |=> GRANT_HANG_N_O && EXT_BUS_GRANT_N_O)
    else $error("hang or grant stuck");
  emu_grant_a: assert property (@(posedge CORE_CLK_I)
    !emu_on |=> EMU_ALT_BUS_GRANT_N_O)
    else $error("alternate grant outside emulation");
  grant_hold_a: assert property (@(posedge CORE_CLK_I)
    req_hold_s |=> !EXT_BUS_GRANT_N_O && !BUS_DRIVE_EN_O)
    else $error("grant lost while requested");
  grant_cycle_a: assert property (@(posedge CORE_CLK_I)
    req_free_s ##1 req_drop_s |=>
      EXT_BUS_GRANT_N_O && BUS_DRIVE_EN_O)
    else $error("bus not returned after short grant");
  halt_grant_a: assert property (@(posedge CORE_CLK_I)
    grant && !CONTINUE_MODE_I |=> CORE_HALT_O)
    else $error("execution not halted on grant");
  hang_set_a: assert property (@(posedge CORE_CLK_I)
    grant && ACCESS_WANTED_I |=> !GRANT_HANG_N_O)
    else $error("stall not shown on hang");
  reset_grant_a: assert property (@(posedge CORE_CLK_I)
    !RST_N_I && req_act && !ACCESS_BUSY_I |=> !BUS_DRIVE_EN_O)
    else $error("request ignored while reset held");
  emu_reset_a: assert property (@(posedge CORE_CLK_I)
    emu_on && !sync2_reg[2] |=> !CORE_RESET_N_O)
    else $error("alternate reset not taken");
  oe_normal_a: assert property (@(posedge CORE_CLK_I)
    !emu_on |=> EXT_BUS_GRANT_OE_O)
    else $error("grant pin floats outside emulation");
  emu_alt_grant_a: assert property (@(posedge CORE_CLK_I)
    emu_on && req_act && !ACCESS_BUSY_I |=> !EMU_ALT_BUS_GRANT_N_O)
    else $error("alternate grant not given");

endmodule

// ---- verification/ebrg_master.sv ----
/*
 * Outside bus master model that borrows the external memory bus.
 * Assumes grant is sampled on the core clock.
 */
module ebrg_master (
  input wire logic clk_i,
  input wire logic want_i,
  input wire logic grant_n_i,
  output logic req_n_o,
  output logic drive_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req_n_o = 1'b1;
  initial drive_o = 1'b0;
  // Lines let go one cycle before the request drops
  always @(negedge clk_i)
  begin
    drive_o <= want_i && !grant_n_i;
    req_n_o <= !(want_i || drive_o);
  end
endmodule

// ---- verification/test_external_bus_request_grant.sv ----
/*
 * Bench for the bus request and grant block.
 * Assumes a request is answered within four clock cycles.
 */
module test_external_bus_request_grant;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0;
  logic rst_n, want, ar_n, art_n, emu, busy, wtd, cont;
  logic req_n, drv, g_n, oe, ag_n, h_n, den, halt, cr_n;
  int errors, check_count;
  // Rows: wanted, continue, halt, hang_n
  logic [3:0] rows [4] = '{4'h3, 4'h5, 4'hE, 4'hA};
  ebrg_master ebrg_master_i (.clk_i(clk), .want_i(want),
    .grant_n_i(g_n), .req_n_o(req_n), .drive_o(drv));
  ebrg_arbiter ebrg_arbiter_i (.CORE_CLK_I(clk), .RST_N_I(rst_n),
    .EXT_BUS_REQ_N_I(req_n), .EMU_ALT_BUS_REQ_N_I(ar_n),
    .EMU_ALT_RESET_N_I(art_n), .EMULATOR_ENABLE_I(emu),
    .ACCESS_BUSY_I(busy), .ACCESS_WANTED_I(wtd),
    .CONTINUE_MODE_I(cont), .EXT_BUS_GRANT_N_O(g_n),
    .EXT_BUS_GRANT_OE_O(oe), .EMU_ALT_BUS_GRANT_N_O(ag_n),
    .GRANT_HANG_N_O(h_n), .BUS_DRIVE_EN_O(den),
    .CORE_HALT_O(halt), .CORE_RESET_N_O(cr_n));
  task cmp(input logic got, input logic exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task finish_test;
    if (errors == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    forever #2.5 clk = ~clk;
  end
  // Hang guard
  initial
  begin
    #100us;
    errors++;
    finish_test;
  end
  initial
  begin
    {rst_n, want, emu, busy, wtd, cont} = 6'h00;
    {ar_n, art_n} = 2'h3;
    cyc(5);
    rst_n <= 1'h1;
    for (int i = 0; i < 4; i++)
    begin
      {wtd, cont} <= rows[i][3:2];
      want <= 1'h1;
      cyc(5);
      cmp(g_n, 1'h0);
      cmp(den, 1'h0);
      cmp(drv, 1'h1);
      cmp(halt, rows[i][1]);
      cmp(h_n, rows[i][0]);
      cmp(oe, 1'h1);
      cmp(ag_n, 1'h1);
      cmp(cr_n, 1'h1);
      want <= 1'h0;
      cyc(6);
      cmp(g_n, 1'h1);
      cmp(h_n, 1'h1);
      cmp(den, 1'h1);
      cmp(halt, 1'h0);
      cmp(drv, 1'h0);
    end
    // Request during an access waits for its end
    busy <= 1'h1;
    want <= 1'h1;
    cyc(8);
    cmp(g_n, 1'h1);
    busy <= 1'h0;
    cyc(1);
    cmp(g_n, 1'h0);
    want <= 1'h0;
    cyc(6);
    // Reset held again mid-run, request still honoured
    rst_n <= 1'h0;
    want <= 1'h1;
    cyc(5);
    cmp(g_n, 1'h0);
    cmp(cr_n, 1'h0);
    want <= 1'h0;
    cyc(6);
    cmp(g_n, 1'h1);
    rst_n <= 1'h1;
    // Emulation takes the alternate pins
    emu <= 1'h1;
    {ar_n, art_n} <= 2'h0;
    cyc(5);
    cmp(oe, 1'h0);
    cmp(ag_n, 1'h0);
    cmp(den, 1'h0);
    cmp(cr_n, 1'h0);
    // Normal request ignored while emulating
    {ar_n, art_n} <= 2'h3;
    want <= 1'h1;
    cyc(5);
    cmp(ag_n, 1'h1);
    cmp(g_n, 1'h1);
    cmp(cr_n, 1'h1);
    finish_test;
  end
endmodule
